// >>> verilog/fast_swap_pkg.sv
package fast_swap_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_SRC_CTRL   = 8'hb1;
    localparam logic [7:0] ADDR_SNK_CTRL   = 8'hb2;
    localparam logic [7:0] ADDR_ALERT_FLAG = 8'hb3;
    localparam logic [7:0] ADDR_ALERT_EN   = 8'hb4;

    // Field positions
    localparam int SWAP_START_BIT  = 0;
    localparam int HOST_SINK_BIT   = 1;
    localparam int DELAY_SEL_LSB   = 2;
    localparam int DELAY_SEL_MSB   = 3;
    localparam int DETECT_ARM_BIT  = 0;
    localparam int FLAG_SWAP_RX    = 0;
    localparam int FLAG_SWAP_TX    = 1;
    localparam int FLAG_OTP        = 2;
    localparam int FLAG_SUPPLY     = 3;
    localparam int FLAG_INPUT1     = 4;
    localparam int FLAG_INPUT2     = 5;
    localparam int FLAG_DISCHARGE  = 6;
    localparam int NUM_FLAGS       = 7;

    // Reset values
    localparam logic [7:0] SRC_CTRL_RESET  = 8'h00;
    localparam logic [0:0] SNK_CTRL_RESET  = 1'h0;
    localparam logic [6:0] FLAGS_RESET     = 7'h00;
    localparam logic [6:0] ENABLES_RESET   = 7'h7f;

    // Delay selection codes
    localparam logic [1:0] DELAY_NONE = 2'h0;
    localparam logic [1:0] DELAY_ONE  = 2'h1;
    localparam logic [1:0] DELAY_TWO  = 2'h2;

    // Timing
    localparam int CLK_MHZ      = 100;
    localparam int DELAY_ONE_US = 150;
    localparam int DELAY_TWO_US = 300;
    localparam int DELAY_THR_US = 600;
    localparam int DELAY_ONE_CYC = DELAY_ONE_US * CLK_MHZ;
    localparam int DELAY_TWO_CYC = DELAY_TWO_US * CLK_MHZ;
    localparam int DELAY_THR_CYC = DELAY_THR_US * CLK_MHZ;
    localparam int CNT_W         = 16;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b001,
        ST_WAIT_SIG = 3'b010,
        ST_COUNT    = 3'b100
    } gate_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic discharge_done;
        logic swap_rx;
        logic swap_tx_done;
        logic vbus_disconnect;
    } swap_evt_t;

endpackage : fast_swap_pkg

// >>> verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
    input  wire logic i_mclk,
    input  wire logic i_rst,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign o_level = sync_q;
    assign o_rise  = sync_q & ~prev_q;
    assign o_fall  = ~sync_q & prev_q;
endmodule : pin_sync

// >>> verilog/fast_swap_alert_regs.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module fast_swap_alert_regs
    import fast_swap_pkg::*;
#(
    parameter int unsigned DLY_ONE_CYC = DELAY_ONE_CYC,
    parameter int unsigned DLY_TWO_CYC = DELAY_TWO_CYC,
    parameter int unsigned DLY_THR_CYC = DELAY_THR_CYC
) (
    input  wire logic      i_mclk,
    input  wire logic      i_rst,
    input  wire reg_req_t  i_reg_req,
    input  wire swap_evt_t i_evt,
    input  wire logic      i_input1,
    input  wire logic      i_input2,
    input  wire logic      i_supply_det,
    input  wire logic      i_otp_det,
    input  wire logic      i_pin_swap_function,
    input  wire logic      i_out2_level,
    input  wire logic      i_out2_en,
    input  wire logic      i_in2_monitor,
    output logic [7:0]     o_reg_rdata,
    output logic           o_swap_tx_start,
    output logic           o_swap_detect_en,
    output logic           o_sink_gate_en,
    output logic           o_alert,
    output logic           o_gpio2_out,
    output logic           o_gpio2_oe_n
);

    function automatic logic wr_hit(input reg_req_t req, input logic [7:0] addr);
        wr_hit = req.wr && (req.addr == addr);
    endfunction : wr_hit

    function automatic logic [CNT_W-1:0] delay_cycles(input logic [1:0] sel);
        case (sel)
            DELAY_ONE: delay_cycles = CNT_W'(DLY_ONE_CYC - 1);
            DELAY_TWO: delay_cycles = CNT_W'(DLY_TWO_CYC - 1);
            default:   delay_cycles = CNT_W'(DLY_THR_CYC - 1);
        endcase
    endfunction : delay_cycles

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [3:0] pin_raw;
    logic [3:0] pin_lvl;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;

    assign pin_raw = {i_otp_det, i_supply_det, i_input2, i_input1};

    generate
        for (genvar g = 0; g < 4; g++) begin : g_sync
            pin_sync u_sync (
                .i_mclk  (i_mclk),
                .i_rst   (i_rst),
                .i_pin   (pin_raw[g]),
                .o_level (pin_lvl[g]),
                .o_rise  (pin_rise[g]),
                .o_fall  (pin_fall[g])
            );
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Swap start and detect arm
    logic       swap_start_cmd;
    logic       gpio_go;
    logic       swap_begin;
    logic       swap_start_q;
    logic [2:0] src_cfg_q;
    logic [2:0] src_cfg_now;
    logic       arm_q;
    logic       arm_wr;
    logic       rx_seen;

    assign swap_start_cmd = wr_hit(i_reg_req, ADDR_SRC_CTRL)
                          & i_reg_req.wdata[SWAP_START_BIT];
    assign gpio_go = i_pin_swap_function & ~i_out2_en & i_in2_monitor & pin_fall[1];
    assign swap_begin = swap_start_cmd | gpio_go;
    assign src_cfg_now = wr_hit(i_reg_req, ADDR_SRC_CTRL)
                       ? i_reg_req.wdata[DELAY_SEL_MSB:HOST_SINK_BIT] : src_cfg_q;
    assign arm_wr = wr_hit(i_reg_req, ADDR_SNK_CTRL) & i_reg_req.wdata[DETECT_ARM_BIT];
    assign rx_seen = arm_q & i_evt.swap_rx;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            swap_start_q    <= 1'b0;
            src_cfg_q       <= SRC_CTRL_RESET[DELAY_SEL_MSB:HOST_SINK_BIT];
            o_swap_tx_start <= 1'b0;
        end else begin
            swap_start_q    <= swap_start_cmd;
            src_cfg_q       <= src_cfg_now;
            o_swap_tx_start <= swap_begin;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            arm_q            <= SNK_CTRL_RESET[0];
            o_swap_detect_en <= SNK_CTRL_RESET[0];
        end else begin
            arm_q            <= arm_wr | (arm_q & ~rx_seen);
            o_swap_detect_en <= arm_wr | (arm_q & ~rx_seen);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Sink gate sequencing
    gate_state_t      state_q;
    logic [CNT_W-1:0] cnt_q;
    logic             host_sink;
    logic [1:0]       delay_sel;

    assign host_sink = src_cfg_now[0];
    assign delay_sel = src_cfg_now[2:1];

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_q        <= ST_IDLE;
            cnt_q          <= '0;
            o_sink_gate_en <= 1'b0;
        end else if (swap_begin) begin
            cnt_q <= delay_cycles(delay_sel);
            if (host_sink) begin
                state_q        <= ST_IDLE;
                o_sink_gate_en <= 1'b0;
            end else if (delay_sel == DELAY_NONE) begin
                state_q        <= ST_IDLE;
                o_sink_gate_en <= 1'b1;
            end else begin
                state_q        <= ST_WAIT_SIG;
                o_sink_gate_en <= 1'b0;
            end
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
                ST_WAIT_SIG: begin
                    if (i_evt.swap_tx_done) begin
                        state_q <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (cnt_q == '0) begin
                        state_q        <= ST_IDLE;
                        o_sink_gate_en <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Alert flags and enables
    logic [6:0] flags_q;
    logic [6:0] mask_q;
    logic [6:0] flag_set;
    logic [6:0] flag_clr;

    always_comb begin
        flag_set                 = '0;
        flag_set[FLAG_DISCHARGE] = i_evt.discharge_done;
        flag_set[FLAG_INPUT2]    = pin_rise[1] | pin_fall[1];
        flag_set[FLAG_INPUT1]    = pin_rise[0] | pin_fall[0];
        flag_set[FLAG_SUPPLY]    = pin_rise[2] | pin_fall[2];
        flag_set[FLAG_OTP]       = pin_rise[3];
        flag_set[FLAG_SWAP_TX]   = gpio_go;
        flag_set[FLAG_SWAP_RX]   = rx_seen;
    end

    assign flag_clr = wr_hit(i_reg_req, ADDR_ALERT_FLAG) ? i_reg_req.wdata[6:0] : '0;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            flags_q <= FLAGS_RESET;
        end else begin
            flags_q <= (flags_q & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mask_q <= ENABLES_RESET;
        end else if (wr_hit(i_reg_req, ADDR_ALERT_EN)) begin
            mask_q <= i_reg_req.wdata[6:0];
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_alert <= 1'b0;
        end else begin
            o_alert <= |(flags_q & mask_q);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin two output
    logic sink_fn;
    logic disc_low_q;
    logic disc_low_d;

    assign sink_fn    = i_pin_swap_function & i_out2_en;
    assign disc_low_d = sink_fn & i_out2_level & (disc_low_q | i_evt.vbus_disconnect);

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            disc_low_q   <= 1'b0;
            o_gpio2_out  <= 1'b0;
            o_gpio2_oe_n <= 1'b1;
        end else begin
            disc_low_q   <= disc_low_d;
            o_gpio2_out  <= i_out2_level & ~disc_low_d;
            o_gpio2_oe_n <= ~i_out2_en;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Register read
    logic [7:0] rd_val;

    always_comb begin
        case (i_reg_req.addr)
            ADDR_SRC_CTRL:   rd_val = {4'h0, src_cfg_q, swap_start_q};
            ADDR_SNK_CTRL:   rd_val = {7'h00, arm_q};
            ADDR_ALERT_FLAG: rd_val = {1'b0, flags_q};
            ADDR_ALERT_EN:   rd_val = {1'b0, mask_q};
            default:         rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_req.rd) begin
            o_reg_rdata <= rd_val;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    start_self_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        swap_start_cmd |=> (swap_start_q && o_swap_tx_start)
            ##1 (!swap_start_q || $past(swap_start_cmd)))
        else $error("swap start bit did not pulse and clear");
    start_zero_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (wr_hit(i_reg_req, ADDR_SRC_CTRL) && !i_reg_req.wdata[0] && !gpio_go) |=> !o_swap_tx_start)
        else $error("writing zero started a swap");
    gate_now_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (swap_begin && !host_sink && delay_sel == DELAY_NONE) |=> o_sink_gate_en)
        else $error("sink gate not enabled at swap start");
    gate_manual_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (swap_begin && host_sink) |=> !o_sink_gate_en [*4])
        else $error("sink gate enabled under host control");
    gate_waits_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (state_q == ST_WAIT_SIG && !i_evt.swap_tx_done && !swap_begin) |=> !o_sink_gate_en)
        else $error("sink gate enabled before signalling done");
    gate_expiry_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (state_q == ST_COUNT && cnt_q == '0 && !swap_begin)
            |=> o_sink_gate_en && state_q == ST_IDLE)
        else $error("sink gate not enabled at delay expiry");
    arm_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (rx_seen && !arm_wr) |=> !o_swap_detect_en && flags_q[FLAG_SWAP_RX])
        else $error("detect arm not cleared on detection");
    flag_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        ##1 ((flags_q & ~$past(flag_clr)) & $past(flags_q)) == ($past(flags_q) & ~$past(flag_clr)))
        else $error("alert flag lost without a clear");
    flag_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (flag_clr != '0 && flag_set == '0) |=> (flags_q & $past(flag_clr)) == '0)
        else $error("alert flag not cleared by write of one");
    otp_flag_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        $rose(pin_lvl[3]) |-> ##1 flags_q[FLAG_OTP])
        else $error("over-temperature flag not set");
    swap_sent_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        gpio_go |=> o_swap_tx_start && flags_q[FLAG_SWAP_TX])
        else $error("pin-driven swap not sent and flagged");
    alert_req_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        ((flags_q & mask_q) != '0) |=> o_alert)
        else $error("alert request missing for unmasked flag");
    alert_drop_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        ((flags_q & mask_q) == '0) |=> !o_alert)
        else $error("alert request with no unmasked flag");
    disc_low_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (sink_fn && i_out2_level && i_evt.vbus_disconnect) |=> !o_gpio2_out && !o_gpio2_oe_n)
        else $error("pin two not driven low on disconnect");

endmodule : fast_swap_alert_regs

// >>> testbench/host_port_model.sv
`timescale 1ns/1ps
module host_port_model
    import fast_swap_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_reg_rdata,
    output reg_req_t        o_reg_req
);

    initial o_reg_req = '0;

    ////////////////////////////////////////////////////////////////////////
    // Strobes held across one rising edge; released fields show garbage
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge i_mclk);
        o_reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge i_mclk);
        o_reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask : reg_write

    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(negedge i_mclk);
        o_reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge i_mclk);
        o_reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
        data = i_reg_rdata;
    endtask : reg_read

endmodule : host_port_model

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb
    import fast_swap_pkg::*;
;
    localparam int D1 = 5;
    localparam int D2 = 10;
    localparam int D3 = 20;
    logic       mclk, rst, gpi1, gpi2, sup, otp, fn, lvl, oen, mon;
    logic       tx, det, gate, alert, g2o, g2_oe_n;
    swap_evt_t  evt;
    reg_req_t   req;
    logic [7:0] rdata, v;
    int         n_errors, checks, n;
    int         dly [3] = '{D1, D2, D3};
    int         fbit [5] = '{6, 5, 4, 3, 2};

    host_port_model host (.i_mclk(mclk), .i_reg_rdata(rdata), .o_reg_req(req));

    fast_swap_alert_regs #(.DLY_ONE_CYC(D1), .DLY_TWO_CYC(D2), .DLY_THR_CYC(D3)) uut (
        .i_mclk(mclk), .i_rst(rst), .i_reg_req(req), .i_evt(evt),
        .i_input1(gpi1), .i_input2(gpi2), .i_supply_det(sup), .i_otp_det(otp),
        .i_pin_swap_function(fn), .i_out2_level(lvl), .i_out2_en(oen),
        .i_in2_monitor(mon), .o_reg_rdata(rdata), .o_swap_tx_start(tx),
        .o_swap_detect_en(det), .o_sink_gate_en(gate), .o_alert(alert),
        .o_gpio2_out(g2o), .o_gpio2_oe_n(g2_oe_n));

    always #5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : check_byte

    task automatic check_bit(string what, logic exp, logic got);
        checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %b seen %b", what, exp, got);
            n_errors++;
        end
    endtask : check_bit

    task automatic rd_chk(logic [7:0] addr, logic [7:0] exp);
        host.reg_read(addr, v);
        check_byte($sformatf("reg %h", addr), exp, v);
    endtask : rd_chk

    task automatic pulse(logic [3:0] m);
        @(negedge mclk);
        evt = swap_evt_t'(m);
        @(negedge mclk);
        evt = '0;
    endtask : pulse

    // Bounded wait on gate (sel 0) or swap start pulse (sel 1)
    task automatic wait_for(input int sel, output int cnt);
        for (cnt = 1; cnt <= 300; cnt++) begin
            @(posedge mclk);
            #1;
            if ((sel == 0 && gate === 1'b1) || (sel == 1 && tx === 1'b1)) return;
        end
        n_errors++;
        complete_run();
    endtask : wait_for

    task automatic fire(int k);
        @(negedge mclk);
        case (k)
            0: pulse(4'b1000);
            1: gpi2 = ~gpi2;
            2: gpi1 = ~gpi1;
            3: sup = ~sup;
            default: otp = 1'b1;
        endcase
    endtask : fire

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {mclk, gpi1, gpi2, sup, otp, fn, lvl, oen, mon} = '0;
        evt = '0;
        rst = 1'b1;
        n_errors = 0;
        checks = 0;
        repeat (3) @(negedge mclk);
        check_bit("oe_n in reset", 1'b1, g2_oe_n);
        rst = 1'b0;
        rd_chk(ADDR_SRC_CTRL, 8'h00);
        rd_chk(ADDR_SNK_CTRL, 8'h00);
        rd_chk(ADDR_ALERT_FLAG, 8'h00);
        rd_chk(ADDR_ALERT_EN, 8'h7f);
        host.reg_write(8'hb5, 8'hff);
        rd_chk(8'hb5, 8'h00);
        rd_chk(ADDR_ALERT_EN, 8'h7f);
        // Immediate gate with code 00
        host.reg_write(ADDR_SRC_CTRL, 8'h01);
        check_bit("tx start", 1'b1, tx);
        @(negedge mclk);
        check_bit("tx start end", 1'b0, tx);
        check_bit("gate code 0", 1'b1, gate);
        rd_chk(ADDR_SRC_CTRL, 8'h00);
        host.reg_write(ADDR_SRC_CTRL, 8'h00);
        check_bit("tx on zero", 1'b0, tx);
        // Delayed gate codes
        for (int c = 1; c <= 3; c++) begin
            host.reg_write(ADDR_SRC_CTRL, 8'(c << 2) | 8'h01);
            @(negedge mclk);
            check_bit("gate cleared", 1'b0, gate);
            pulse(4'b0010);
            wait_for(0, n);
            check_byte("gate delay", 8'(dly[c-1]), 8'(n));
        end
        rd_chk(ADDR_SRC_CTRL, 8'h0c);
        host.reg_write(ADDR_SRC_CTRL, 8'h07);
        pulse(4'b0010);
        repeat (40) @(negedge mclk);
        check_bit("gate host ctrl", 1'b0, gate);
        // Swap detection
        pulse(4'b0100);
        repeat (2) @(negedge mclk);
        rd_chk(ADDR_ALERT_FLAG, 8'h00);
        host.reg_write(ADDR_SNK_CTRL, 8'h01);
        check_bit("detect en", 1'b1, det);
        rd_chk(ADDR_SNK_CTRL, 8'h01);
        pulse(4'b0100);
        repeat (2) @(negedge mclk);
        check_bit("detect cleared", 1'b0, det);
        check_bit("alert rx", 1'b1, alert);
        rd_chk(ADDR_SNK_CTRL, 8'h00);
        host.reg_write(ADDR_ALERT_FLAG, 8'h00);
        rd_chk(ADDR_ALERT_FLAG, 8'h01);
        host.reg_write(ADDR_ALERT_FLAG, 8'h01);
        repeat (2) @(negedge mclk);
        check_bit("alert cleared", 1'b0, alert);
        // Each event source sets its own flag
        for (int k = 0; k < 5; k++) begin
            fire(k);
            repeat (6) @(negedge mclk);
            rd_chk(ADDR_ALERT_FLAG, 8'(1 << fbit[k]));
            check_bit("alert event", 1'b1, alert);
            host.reg_write(ADDR_ALERT_FLAG, 8'(1 << fbit[k]));
            repeat (2) @(negedge mclk);
            check_bit("alert clear", 1'b0, alert);
        end
        otp = 1'b0;
        repeat (6) @(negedge mclk);
        rd_chk(ADDR_ALERT_FLAG, 8'h00);
        // Masking
        host.reg_write(ADDR_ALERT_EN, 8'h00);
        rd_chk(ADDR_ALERT_EN, 8'h00);
        pulse(4'b1000);
        repeat (3) @(negedge mclk);
        check_bit("alert masked", 1'b0, alert);
        rd_chk(ADDR_ALERT_FLAG, 8'h40);
        host.reg_write(ADDR_ALERT_EN, 8'h40);
        repeat (2) @(negedge mclk);
        check_bit("alert unmasked", 1'b1, alert);
        host.reg_write(ADDR_ALERT_FLAG, 8'h40);
        host.reg_write(ADDR_ALERT_EN, 8'h7f);
        // Source mode: falling pin two sends a swap
        @(negedge mclk);
        {fn, oen, mon} = 3'b101;
        repeat (2) @(negedge mclk);
        gpi2 = 1'b0;
        wait_for(1, n);
        repeat (4) @(negedge mclk);
        rd_chk(ADDR_ALERT_FLAG, 8'h22);
        host.reg_write(ADDR_ALERT_FLAG, 8'h22);
        // Sink mode: disconnect drives pin two low
        @(negedge mclk);
        {oen, lvl, mon} = 3'b110;
        repeat (3) @(negedge mclk);
        check_bit("pin2 oe_n", 1'b0, g2_oe_n);
        check_bit("pin2 high", 1'b1, g2o);
        pulse(4'b0001);
        check_bit("pin2 low", 1'b0, g2o);
        repeat (3) @(negedge mclk);
        check_bit("pin2 held", 1'b0, g2o);
        complete_run();
    end

endmodule : tb
